// ===== pvi_pkg.sv
package pvi_pkg;
    localparam int PIX_W         = 24;
    localparam int GPIO_N        = 6;
    localparam int GPO_N         = 3;
    localparam int FILT_MIN_CLKS = 3;
    localparam int FILT_CNT_W    = 2;
    localparam int GPIO_BIT0     = 0;
    localparam int GPIO_BIT1     = 1;
    localparam int GPIO_BIT2     = 8;
    localparam int GPIO_BIT3     = 9;
    localparam int GPIO_BIT4     = 16;
    localparam int GPIO_BIT5     = 17;
    localparam int SHARED_BIT    = 17;
    localparam logic [2:0] GPO_RESET = 3'h0;
endpackage

// ===== pvi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pvi_link_if;
    logic [23:0] pix;
    logic        line_sync;
    logic        frame_sync;
    logic        active_video;
    logic        filter_en;
    modport filt (input pix, input line_sync, input frame_sync,
                  input active_video, input filter_en);
    modport cap  (output pix, output line_sync, output frame_sync,
                  output active_video, output filter_en);
endinterface
`default_nettype wire

// ===== pvi_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pvi_filter
(
    input  wire logic     clk_pix,
    input  wire logic     rst_pix_n,
    pvi_link_if.filt      lk,
    output var  logic     line_sync_q,
    output var  logic     active_video_q
);
    import pvi_pkg::*;

    logic [1:0] lvl;
    logic [1:0] out_q;
    logic [1:0] out_d;
    logic [1:0][FILT_CNT_W-1:0] cnt_q;
    logic [1:0][FILT_CNT_W-1:0] cnt_d;

    assign lvl = {lk.active_video, lk.line_sync};

    always_comb
    begin
        out_d = out_q;
        cnt_d = cnt_q;
        for (int i = 0; i < 2; i++)
        begin
            if (!lk.filter_en)
            begin
                out_d[i] = lvl[i];
                cnt_d[i] = '0;
            end
            else if (lvl[i] == out_q[i])
                cnt_d[i] = '0;
            else if (cnt_q[i] == FILT_CNT_W'(FILT_MIN_CLKS - 1))
            begin
                out_d[i] = lvl[i];
                cnt_d[i] = '0;
            end
            else
                cnt_d[i] = cnt_q[i] + 2'h1;
        end
    end

    always_ff @(posedge clk_pix or negedge rst_pix_n)
    begin
        if (!rst_pix_n)
        begin
            out_q <= 2'h0;
            cnt_q <= '0;
        end
        else
        begin
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    assign line_sync_q    = out_q[0];
    assign active_video_q = out_q[1];

    // Level must persist 3 clocks before output follows
    property p_filter_min;
        @(posedge clk_pix) disable iff (!rst_pix_n)
        (lk.filter_en && $changed(out_q[0])) |->
            $past(lk.line_sync, 1) == out_q[0] &&
            $past(lk.line_sync, 3) == out_q[0];
    endproperty
    a_filter_min: assert property (p_filter_min)
        else $error("line sync passed a short pulse");

    property p_bypass;
        @(posedge clk_pix) disable iff (!rst_pix_n)
        (!lk.filter_en) ##1 1 |-> out_q[1] == $past(lvl[1]);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("unfiltered enable not forwarded");
endmodule
`default_nettype wire

// ===== pvi_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Accept 24 pixel bits as red, green, blue bytes; forward all but enabled GPIO and 18-bit shared-pin bits.
// - Selectable pixel clock edge strobes data and control inputs.
// - With filter on, line sync and enable pulses under 3 clocks dropped.
// - With filter off, sync and enable pass with no minimum width.
// - Pixel bits 0,1,8,9,16,17 may serve as general-purpose I/O 0-5.
// - Audio clock, word clock, first data may become outputs 8,7,6.
// - In 18-bit mode shared pin is second audio data input.
// - General-purpose I/O 0-3 offered only in 18-bit mode.
// - Power-down low resets all configuration to defaults.
module pvi_top
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     clk_pix,
    input  wire logic                     power_down_n,
    input  wire logic [pvi_pkg::PIX_W-1:0] pix_in,
    input  wire logic                     line_sync_in,
    input  wire logic                     frame_sync_in,
    input  wire logic                     active_video_flag,
    input  wire logic                     audio_bclk_in,
    input  wire logic                     audio_wclk_in,
    input  wire logic                     audio_data_in,
    input  wire logic                     cfg_strobe_edge_select,
    input  wire logic                     cfg_filter_en,
    input  wire logic                     cfg_mode18_pin,
    input  wire logic                     cfg_mode18_reg,
    input  wire logic [5:0]               cfg_gpio_en,
    input  wire logic [5:0]               cfg_gpio_dir_out,
    input  wire logic [5:0]               cfg_gpio_out_val,
    input  wire logic [2:0]               cfg_gpo_en,
    input  wire logic [2:0]               cfg_gpo_val,
    output var  logic [pvi_pkg::PIX_W-1:0] pix_out,
    output var  logic                     line_sync_out,
    output var  logic                     frame_sync_out,
    output var  logic                     active_video_out,
    output var  logic                     second_audio_data_in,
    output var  logic                     second_audio_valid,
    output var  logic [5:0]               gpio_in_val,
    output var  logic [5:0]               gpio_pad_out,
    output var  logic [5:0]               gpio_pad_oe_n,
    output var  logic [2:0]               register_driven_output,
    output var  logic [2:0]               gpo_pad_oe_n
);
    import pvi_pkg::*;

    localparam int GPIO_MAP [GPIO_N] = '{GPIO_BIT0, GPIO_BIT1, GPIO_BIT2,
                                         GPIO_BIT3, GPIO_BIT4, GPIO_BIT5};

    // Reset release synchroniser; power-down acts as a reset too
    logic rs1_q;
    logic rs2_q;
    logic rst_raw_n;
    logic rs2_d_w;
    assign rst_raw_n = rst_n & power_down_n;
    always_ff @(posedge clk_sys or negedge rst_raw_n)
    begin
        if (!rst_raw_n)
        begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rs2_q <= rs2_d_w;
        end
    end
    assign rs2_d_w = rs1_q;

    // Pixel domain reset release
    logic pr1_q;
    logic pr2_q;
    always_ff @(posedge clk_pix or negedge rst_raw_n)
    begin
        if (!rst_raw_n)
        begin
            pr1_q <= 1'b0;
            pr2_q <= 1'b0;
        end
        else
        begin
            pr1_q <= 1'b1;
            pr2_q <= pr1_q;
        end
    end

    // Config levels into the pixel domain, two flops each
    logic [2:0] cs1_q;
    logic [2:0] cs2_q;
    logic       edge_neg;
    logic       mode18;
    always_ff @(posedge clk_pix or negedge pr2_q)
    begin
        if (!pr2_q)
        begin
            cs1_q <= 3'h0;
            cs2_q <= 3'h0;
        end
        else
        begin
            cs1_q <= {cfg_mode18_pin | cfg_mode18_reg, cfg_filter_en,
                      cfg_strobe_edge_select};
            cs2_q <= cs1_q;
        end
    end
    assign edge_neg = cs2_q[0];

    // sample on both edges, keep one
    logic [PIX_W+2:0] cap_p_q;
    logic [PIX_W+2:0] cap_n_q;
    logic [PIX_W+2:0] cap_in;
    assign cap_in = {active_video_flag, frame_sync_in, line_sync_in, pix_in};
    always_ff @(posedge clk_pix or negedge pr2_q)
    begin
        if (!pr2_q)
            cap_p_q <= '0;
        else
            cap_p_q <= cap_in;
    end
    always_ff @(negedge clk_pix or negedge pr2_q)
    begin
        if (!pr2_q)
            cap_n_q <= '0;
        else
            cap_n_q <= cap_in;
    end

    logic [PIX_W+2:0] sel_q;
    logic [PIX_W+2:0] sel_d;
    always_comb
    begin
        sel_d = edge_neg ? cap_n_q : cap_p_q;
    end
    always_ff @(posedge clk_pix or negedge pr2_q)
    begin
        if (!pr2_q)
            sel_q <= '0;
        else
            sel_q <= sel_d;
    end

    pvi_link_if lk ();
    assign lk.pix          = sel_q[PIX_W-1:0];
    assign lk.line_sync    = sel_q[PIX_W];
    assign lk.frame_sync   = sel_q[PIX_W+1];
    assign lk.active_video = sel_q[PIX_W+2];
    assign lk.filter_en    = cs2_q[1];

    logic line_f;
    logic act_f;
    pvi_filter u_filt
    (
        .clk_pix        (clk_pix),
        .rst_pix_n      (pr2_q),
        .lk             (lk),
        .line_sync_q    (line_f),
        .active_video_q (act_f)
    );

    logic [PIX_W-1:0] pix_dly_q;
    logic             fs_dly_q;
    logic [5:0]       gpio_in_q;
    logic             aud2_q;
    logic [5:0]       gpio_en_pix;
    logic [5:0]       gsync1_q;
    logic [5:0]       gsync2_q;
    always_ff @(posedge clk_pix or negedge pr2_q)
    begin
        if (!pr2_q)
        begin
            gsync1_q <= 6'h00;
            gsync2_q <= 6'h00;
        end
        else
        begin
            gsync1_q <= cfg_gpio_en;
            gsync2_q <= gsync1_q;
        end
    end
    assign gpio_en_pix = {gsync2_q[5:4], gsync2_q[3:0] & {4{cs2_q[2]}}};

    logic [PIX_W-1:0] pix_masked;
    // GPIO pins masked out of pixels
    // shared pin not pixel in 18-bit mode
    always_comb
    begin
        pix_masked = lk.pix;
        for (int g = 0; g < GPIO_N; g++)
            if (gpio_en_pix[g])
                pix_masked[GPIO_MAP[g]] = 1'b0;
        if (cs2_q[2])
            pix_masked[SHARED_BIT] = 1'b0;
    end

    // Data delayed one stage, the same as the filter output with filter off, matching sync alignment
    always_ff @(posedge clk_pix or negedge pr2_q)
    begin
        if (!pr2_q)
        begin
            pix_dly_q <= '0;
            fs_dly_q  <= 1'b0;
            aud2_q    <= 1'b0;
            gpio_in_q <= 6'h00;
        end
        else
        begin
            pix_dly_q <= pix_masked;
            fs_dly_q  <= lk.frame_sync;
            aud2_q    <= cs2_q[2] & lk.pix[SHARED_BIT];
            for (int g = 0; g < GPIO_N; g++)
                gpio_in_q[g] <= gpio_en_pix[g] & lk.pix[GPIO_MAP[g]];
        end
    end

    always_comb
    begin
        pix_out              = pix_dly_q;
        frame_sync_out       = fs_dly_q;
        line_sync_out        = line_f;
        active_video_out     = act_f;
        second_audio_data_in = aud2_q;
        second_audio_valid   = cs2_q[2];
        gpio_in_val          = gpio_in_q;
    end

    // Mode select is pin level OR register bit; two flops before the pad logic reads it
    logic ms1_q;
    logic ms2_q;
    always_ff @(posedge clk_sys or negedge rs2_q)
    begin
        if (!rs2_q)
        begin
            ms1_q <= 1'b0;
            ms2_q <= 1'b0;
        end
        else
        begin
            ms1_q <= cfg_mode18_pin | cfg_mode18_reg;
            ms2_q <= ms1_q;
        end
    end

    // Pad-side outputs on system clock
    logic [5:0] gpo_q;
    logic [5:0] gpo_d;
    logic [5:0] goe_q;
    logic [5:0] goe_d;
    logic [2:0] rdo_q;
    logic [2:0] rdo_d;
    logic [2:0] roe_q;
    logic [2:0] roe_d;
    always_comb
    begin
        gpo_d = cfg_gpio_out_val;
        // pad drive 0-3 needs 18-bit mode
        goe_d = ~(cfg_gpio_en & cfg_gpio_dir_out & {2'h3, {4{ms2_q}}});
        rdo_d = cfg_gpo_val & cfg_gpo_en;
        roe_d = ~cfg_gpo_en;
    end
    always_ff @(posedge clk_sys or negedge rs2_q)
    begin
        if (!rs2_q)
        begin
            gpo_q <= 6'h00;
            goe_q <= 6'h3F;
            rdo_q <= GPO_RESET;
            roe_q <= 3'h7;
        end
        else
        begin
            gpo_q <= gpo_d;
            goe_q <= goe_d;
            rdo_q <= rdo_d;
            roe_q <= roe_d;
        end
    end
    always_comb
    begin
        gpio_pad_out           = gpo_q;
        gpio_pad_oe_n          = goe_q;
        register_driven_output = rdo_q;
        gpo_pad_oe_n           = roe_q;
    end

    property p_gpo_follow;
        @(posedge clk_sys) disable iff (!rs2_q)
        (cfg_gpo_en[0] && $past(rs2_q)) |=>
            register_driven_output[0] == $past(cfg_gpo_val[0])
                          && !gpo_pad_oe_n[0];
    endproperty
    a_gpo_follow: assert property (p_gpo_follow)
        else $error("register output not driven");

    property p_mode18_gpio;
        @(posedge clk_pix) disable iff (!pr2_q)
        !cs2_q[2] |=> gpio_in_q[3:0] == 4'h0;
    endproperty
    a_mode18_gpio: assert property (p_mode18_gpio)
        else $error("gpio 0-3 active outside 18-bit mode");

    property p_pix_pass;
        @(posedge clk_pix) disable iff (!pr2_q)
        (gpio_en_pix == 6'h00 && !cs2_q[2]) |=> pix_out == $past(lk.pix);
    endproperty
    a_pix_pass: assert property (p_pix_pass)
        else $error("pixel data not forwarded");

    property p_frame_align;
        @(posedge clk_pix) disable iff (!pr2_q)
        1'b1 |=> frame_sync_out == $past(lk.frame_sync);
    endproperty
    a_frame_align: assert property (p_frame_align)
        else $error("frame sync out of step with pixels");
endmodule
`default_nettype wire

// ===== pvi_video_src.sv
`timescale 1ns/1ps
`default_nettype none
module pvi_video_src
(
    input  wire logic        clk_pix,
    output var  logic [23:0] pix,
    output var  logic        line_sync,
    output var  logic        frame_sync,
    output var  logic        active_video
);
    initial
    begin
        pix = 24'h000000;
        line_sync = 1'b0;
        frame_sync = 1'b0;
        active_video = 1'b0;
    end
    // Pixel and frame level change on one edge
    task automatic show(input logic [23:0] value, input logic fs);
        @(posedge clk_pix);
        pix <= value;
        frame_sync <= fs;
    endtask
    task automatic pulse(input int width, input logic on_av);
        @(posedge clk_pix);
        line_sync <= !on_av;
        active_video <= on_av;
        repeat (width) @(posedge clk_pix);
        line_sync <= 1'b0;
        active_video <= 1'b0;
    endtask
    // quiet window before any further toggle
    task automatic rest();
        repeat (130) @(posedge clk_pix);
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
`define WAIT_EQ(nm, sig, ex) \
    begin \
        for (int k = 0; k < 10 && (sig) !== (ex); k++) \
            @(negedge clk_pix); \
        `CHK(nm, ex, sig) \
    end
module tb_top;
    import pvi_pkg::*;
    logic        clk_sys = 1'b0;
    logic        clk_pix = 1'b0;
    logic        rst_n = 1'b0;
    logic        power_down_n = 1'b1;
    logic [23:0] pix_in;
    logic        ls_in;
    logic        fs_in;
    logic        av_in;
    logic        edge_sel = 1'b0;
    logic        filt = 1'b0;
    logic        m18p = 1'b0;
    logic        m18r = 1'b0;
    logic [5:0]  gen = 6'h00;
    logic [5:0]  gdir = 6'h00;
    logic [5:0]  gval = 6'h00;
    logic [2:0]  pen = 3'h0;
    logic [2:0]  pval = 3'h0;
    logic [23:0] pix_out;
    logic        ls_out;
    logic        fs_out;
    logic        av_out;
    logic        sad;
    logic        sav;
    logic [5:0]  gin;
    logic [5:0]  gout;
    logic [5:0]  goe;
    logic [2:0]  rdo;
    logic [2:0]  roe;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [23:0] pats [3] = '{24'hFFFFFF, 24'h5A3C96, 24'h000001};

    always #10 clk_sys = ~clk_sys;
    // pixel clock of 8 MHz, free of the system clock
    always #62.5 clk_pix = ~clk_pix;

    pvi_video_src pvi_video_src_inst
    (
        .clk_pix(clk_pix), .pix(pix_in), .line_sync(ls_in),
        .frame_sync(fs_in), .active_video(av_in)
    );

    pvi_top pvi_top_inst
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_pix(clk_pix),
        .power_down_n(power_down_n), .pix_in(pix_in),
        .line_sync_in(ls_in), .frame_sync_in(fs_in),
        .active_video_flag(av_in), .audio_bclk_in(1'b0),
        .audio_wclk_in(1'b0), .audio_data_in(1'b0),
        .cfg_strobe_edge_select(edge_sel), .cfg_filter_en(filt),
        .cfg_mode18_pin(m18p), .cfg_mode18_reg(m18r),
        .cfg_gpio_en(gen), .cfg_gpio_dir_out(gdir),
        .cfg_gpio_out_val(gval), .cfg_gpo_en(pen), .cfg_gpo_val(pval),
        .pix_out(pix_out), .line_sync_out(ls_out),
        .frame_sync_out(fs_out), .active_video_out(av_out),
        .second_audio_data_in(sad), .second_audio_valid(sav),
        .gpio_in_val(gin), .gpio_pad_out(gout), .gpio_pad_oe_n(goe),
        .register_driven_output(rdo), .gpo_pad_oe_n(roe)
    );

    task automatic print_verdict();
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic pix_wait(input int n);
        repeat (n) @(negedge clk_pix);
    endtask

    // Short pulses may vanish, so watch every cycle after the pulse
    task automatic pulse_check(input logic on_av, input int w, input logic ex);
        logic seen;
        seen = 1'b0;
        pvi_video_src_inst.pulse(w, on_av);
        repeat (14)
        begin
            @(negedge clk_pix);
            seen = seen | ls_out | av_out;
        end
        `CHK("ctl pulse", ex, seen)
        pvi_video_src_inst.rest();
    endtask

    // Ceiling is about 2.4 times the expected run
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        pix_wait(10);
        for (int e = 0; e < 2; e++)
        begin
            @(posedge clk_sys);
            edge_sel <= e[0];
            pix_wait(6);
            foreach (pats[i])
            begin
                pvi_video_src_inst.show(pats[i], 1'b0);
                `WAIT_EQ("pix_out", pix_out, pats[i])
            end
        end
        pvi_video_src_inst.show(24'h123456, 1'b1);
        `WAIT_EQ("pix_out", pix_out, 24'h123456)
        `CHK("frame_sync_out", 1'b1, fs_out)
        pvi_video_src_inst.rest();
        for (int f = 0; f < 2; f++)
        begin
            @(posedge clk_sys);
            filt <= f[0];
            pix_wait(6);
            for (int w = 1; w < 4; w++)
                for (int d = 0; d < 2; d++)
                    pulse_check(d[0], w, !f[0] || w >= FILT_MIN_CLKS);
        end
        @(posedge clk_sys);
        pen <= 3'h7;
        pval <= 3'h5;
        gen <= 6'h3F;
        gdir <= 6'h3F;
        gval <= 6'h2A;
        pix_wait(8);
        `CHK("register_driven_output", 3'h5, rdo)
        `CHK("gpo_pad_oe_n", 3'h0, roe)
        `CHK("gpio_pad_oe_n", 6'h0F, goe)
        `CHK("gpio_pad_out", 2'h2, gout[5:4])
        @(posedge clk_sys);
        m18r <= 1'b1;
        pix_wait(8);
        `CHK("gpio_pad_oe_n", 6'h00, goe)
        `CHK("gpio_pad_out", 6'h2A, gout)
        @(posedge clk_sys);
        gdir <= 6'h00;
        pvi_video_src_inst.show(24'h030303, 1'b1);
        pix_wait(8);
        `CHK("gpio_in_val", 6'h3F, gin)
        `CHK("pix_out", 24'h000000, pix_out)
        @(posedge clk_sys);
        gen <= 6'h00;
        m18r <= 1'b0;
        m18p <= 1'b1;
        pix_wait(6);
        pvi_video_src_inst.show(24'h000000, 1'b1);
        `WAIT_EQ("second_audio_data_in", sad, 1'b0)
        pvi_video_src_inst.show(24'h020000, 1'b1);
        `WAIT_EQ("second_audio_data_in", sad, 1'b1)
        `CHK("pix_out", 24'h000000, pix_out)
        `CHK("second_audio_valid", 1'b1, sav)
        @(posedge clk_sys);
        power_down_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        `CHK("register_driven_output", 3'h0, rdo)
        `CHK("gpo_pad_oe_n", 3'h7, roe)
        `CHK("gpio_pad_oe_n", 6'h3F, goe)
        `CHK("second_audio_valid", 1'b0, sav)
        power_down_n <= 1'b1;
        pix_wait(10);
        print_verdict();
    end
endmodule
`default_nettype wire
